// [bsc_evt_flag.sv]
// sticky event flag, set wins over clear
`timescale 1ns/1ns
module bsc_evt_flag (
	input  wire logic i_clk_sys,
	input  wire logic i_arst_n,
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_flag
);
	logic flag_q;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flag_q <= 1'b0;
		end else if (i_set) begin
			flag_q <= 1'b1;
		end else if (i_clr) begin
			flag_q <= 1'b0;
		end
	end

	assign o_flag = flag_q;

	AST_EF_SET_WINS: assert property (@(posedge i_clk_sys)
		disable iff (!i_arst_n) i_set |=> o_flag)
		else $error("event flag lost its set");
	AST_EF_CLEAR: assert property (@(posedge i_clk_sys)
		disable iff (!i_arst_n) i_clr && !i_set |=> !o_flag)
		else $error("event flag not cleared");
endmodule // bsc_evt_flag

// [bsc_host_model.sv]
// host and board side model: primary clock, clock feedback, pins
`timescale 1ns/1ns
module bsc_host_model (
	input  wire logic i_clk_run,
	input  wire logic i_ejector,
	input  wire logic i_pme_req,
	input  wire logic i_sec_clk_out,
	input  wire logic i_lstat_o,
	input  wire logic i_lstat_oe,
	output logic      o_pri_clk,
	output logic      o_sec_clk,
	output logic      o_lstat_pin,
	output logic      o_sec_pme_n
);
	// primary clock, 160 ns, may be stopped at its level
	initial begin
		o_pri_clk = 1'b0;
		#7;
		forever begin
			#80;
			if (i_clk_run) begin
				o_pri_clk = ~o_pri_clk;
			end
		end
	end
	// buffered secondary clock routed back
	assign #3 o_sec_clk = i_sec_clk_out;
	// pin level from the bridge when it drives, else ejector switch
	assign o_lstat_pin = i_lstat_oe ? i_lstat_o : i_ejector;
	assign o_sec_pme_n = ~i_pme_req;
endmodule // bsc_host_model

// [bsc_pin_sync.sv]
// three-stage pin synchroniser with edge pulses
`timescale 1ns/1ns
module bsc_pin_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic i_clk_sys,
	input  wire logic i_arst_n,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// change accepted once stages two and three agree
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			level_q <= RST_VAL;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

	assign o_level = level_q;
	assign o_rise  = !level_q && s2_q && s3_q;
	assign o_fall  = level_q && !s2_q && !s3_q;

	AST_PS_RISE_LEVEL: assert property (@(posedge i_clk_sys)
		disable iff (!i_arst_n) o_rise |=> o_level)
		else $error("rise pulse without level change");
	AST_PS_FALL_LEVEL: assert property (@(posedge i_clk_sys)
		disable iff (!i_arst_n) o_fall |=> !o_level)
		else $error("fall pulse without level change");
endmodule // bsc_pin_sync

// [bsc_pkg.sv]
// constants and types for the bridge clock and sideband event block
package bsc_pkg;
	localparam int SYS_PERIOD_NS   = 20;
	localparam int PCI_CLK_MAX_MHZ = 33;
	localparam int PCI_MIN_PERIOD_NS = (1000 + PCI_CLK_MAX_MHZ - 1)
		/ PCI_CLK_MAX_MHZ;
	localparam int PCI_MIN_PERIOD_CYC =
		(PCI_MIN_PERIOD_NS / SYS_PERIOD_NS) < 1 ? 1 :
		(PCI_MIN_PERIOD_NS / SYS_PERIOD_NS);
	localparam int ROM_BUS_W       = 8;
	localparam int STRAP_SCLK_BIT  = 5;
	localparam logic [2:0] STRAP_WAIT = 3'h4;
	localparam int PIN_PCLK  = 0;
	localparam int PIN_SCLK  = 1;
	localparam int PIN_SPME  = 2;
	localparam int PIN_LSTAT = 3;
	localparam int PIN_STRAP = 4;
	localparam int PIN_N     = 5;
	localparam logic [PIN_N-1:0] PIN_RST_VAL = 5'h14;
	typedef enum logic {
		STRAP_WAITING,
		STRAP_DONE
	} bsc_strap_st_t;
endpackage

// [bsc_top.sv]
// bridge clock output, hot swap and power event sideband logic
// Summary of operation
// - primary inputs sampled and outputs launched on primary clock rise.
// - secondary inputs sampled and outputs launched on secondary clock rise.
// - both bus clocks may run from stopped up to 12.5 MHz, each phase at least two 20 ns system cycles.
// - secondary clock output follows the primary clock at the same frequency.
// - secondary clock output held low by disable bit or low strap bit 5.
// - local status pin as input gives ejector switch state and LED state.
// - local status pin as output drives the hot swap LED value.
// - hot swap event pulled low on insertion or removal event.
// - hot swap event released once software clears the causing bit.
// - power event pulled low on falling input, allowed state and enable set.
// - power event stays low until status or enable bit is cleared.
// - falling edge of subsystem power event input triggers assertion.
// - primary reset asynchronously clears all event and enable state.
`timescale 1ns/1ns
module bsc_top (
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_arst_n,
	input  wire logic                         i_pri_clk,
	input  wire logic                         i_sec_clk,
	output logic                              o_sec_clk_out,
	input  wire logic                         i_sec_clk_dis,
	input  wire logic [bsc_pkg::ROM_BUS_W-1:0] i_rom_addr_data_bus,
	output logic                              o_sec_clk_strap_off,
	input  wire logic                         i_lstat_i,
	output logic                              o_lstat_o,
	output logic                              o_lstat_oe,
	input  wire logic                         i_lstat_drive,
	input  wire logic                         i_led_on,
	output logic                              o_ejector_open,
	output logic                              o_led_state,
	input  wire logic                         i_hs_evt_en,
	input  wire logic                         i_ins_clr,
	input  wire logic                         i_rem_clr,
	output logic                              o_ins_stat,
	output logic                              o_rem_stat,
	output logic                              o_hs_event_o,
	output logic                              o_hs_event_oe,
	input  wire logic                         i_sec_pme_n,
	input  wire logic                         i_pme_en,
	input  wire logic                         i_pme_state_ok,
	input  wire logic                         i_pme_stat_clr,
	output logic                              o_pme_stat,
	output logic                              o_pme_o,
	output logic                              o_pme_oe
);
	logic [bsc_pkg::PIN_N-1:0] pin_raw;
	logic [bsc_pkg::PIN_N-1:0] pin_lvl;
	logic [bsc_pkg::PIN_N-1:0] pin_rise;
	logic [bsc_pkg::PIN_N-1:0] pin_fall;
	logic                      pri_rise;
	logic                      sec_rise;
	logic                      sclk_q;
	logic                      strap_off_q;
	logic [2:0]                strap_cnt_q;
	bsc_pkg::bsc_strap_st_t    strap_st_q;
	logic                      ej_q;
	logic                      ej_prev_q;
	logic                      led_q;
	logic                      led_oe_q;
	logic                      ins_set;
	logic                      rem_set;
	logic                      ins_q;
	logic                      rem_q;
	logic                      enum_oe_q;
	logic                      pme_smp_q;
	logic                      pme_fall;
	logic                      pme_stat_q;
	logic                      pme_oe_q;

	// every outside pin through a three-stage synchroniser
	assign pin_raw[bsc_pkg::PIN_PCLK]  = i_pri_clk;
	assign pin_raw[bsc_pkg::PIN_SCLK]  = i_sec_clk;
	assign pin_raw[bsc_pkg::PIN_SPME]  = i_sec_pme_n;
	assign pin_raw[bsc_pkg::PIN_LSTAT] = i_lstat_i;
	assign pin_raw[bsc_pkg::PIN_STRAP] =
		i_rom_addr_data_bus[bsc_pkg::STRAP_SCLK_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < bsc_pkg::PIN_N; gi++) begin : g_sync
			bsc_pin_sync #(
				.RST_VAL (bsc_pkg::PIN_RST_VAL[gi])
			) u_sync (
				.i_clk_sys (i_clk_sys),
				.i_arst_n  (i_arst_n),
				.i_pin     (pin_raw[gi]),
				.o_level   (pin_lvl[gi]),
				.o_rise    (pin_rise[gi]),
				.o_fall    (pin_fall[gi])
			);
		end
	endgenerate

	// edge-only timing keeps logic valid with a stopped clock
	assign pri_rise = pin_rise[bsc_pkg::PIN_PCLK];
	assign sec_rise = pin_rise[bsc_pkg::PIN_SCLK];

	// strap caught after release once the synchroniser settles
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			strap_st_q  <= bsc_pkg::STRAP_WAITING;
			strap_cnt_q <= 3'h0;
			strap_off_q <= 1'b1;
		end else begin
			case (strap_st_q)
				bsc_pkg::STRAP_WAITING: begin
					strap_cnt_q <= strap_cnt_q + 3'h1;
					if (strap_cnt_q == bsc_pkg::STRAP_WAIT) begin
						strap_off_q <= !pin_lvl[bsc_pkg::PIN_STRAP];
						strap_st_q  <= bsc_pkg::STRAP_DONE;
					end
				end
				bsc_pkg::STRAP_DONE: begin
					strap_cnt_q <= strap_cnt_q;
				end
				default: begin
					strap_st_q <= bsc_pkg::STRAP_WAITING;
				end
			endcase
		end
	end

	// secondary clock copies the primary clock level
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= pin_lvl[bsc_pkg::PIN_PCLK]
				&& !i_sec_clk_dis && !strap_off_q;
		end
	end

	assign o_sec_clk_out       = sclk_q;
	assign o_sec_clk_strap_off = strap_off_q;

	// local status pin, secondary side
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ej_q     <= 1'b0;
			led_q    <= 1'b0;
			led_oe_q <= 1'b0;
		end else if (sec_rise) begin
			led_oe_q <= i_lstat_drive;
			led_q    <= i_led_on;
			if (!led_oe_q) begin
				ej_q <= pin_lvl[bsc_pkg::PIN_LSTAT];
			end
		end
	end

	assign o_lstat_o      = led_q;
	assign o_lstat_oe     = led_oe_q;
	assign o_ejector_open = ej_q;
	assign o_led_state    = led_oe_q ? led_q : ej_q;

	// ejector closing means inserted, opening means removal
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ej_prev_q <= 1'b0;
		end else begin
			ej_prev_q <= ej_q;
		end
	end

	assign ins_set = ej_prev_q && !ej_q;
	assign rem_set = !ej_prev_q && ej_q;

	bsc_evt_flag u_ins_flag (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_set     (ins_set),
		.i_clr     (i_ins_clr),
		.o_flag    (ins_q)
	);

	bsc_evt_flag u_rem_flag (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_set     (rem_set),
		.i_clr     (i_rem_clr),
		.o_flag    (rem_q)
	);

	assign o_ins_stat = ins_q;
	assign o_rem_stat = rem_q;

	// hot swap event launched on the primary clock
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			enum_oe_q <= 1'b0;
		end else if (pri_rise) begin
			enum_oe_q <= (ins_q || rem_q) && i_hs_evt_en;
		end
	end

	assign o_hs_event_o  = 1'b0;
	assign o_hs_event_oe = enum_oe_q;

	// subsystem power event sampled on the primary clock
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pme_smp_q <= 1'b1;
		end else if (pri_rise) begin
			pme_smp_q <= pin_lvl[bsc_pkg::PIN_SPME];
		end
	end

	assign pme_fall = pri_rise && pme_smp_q
		&& !pin_lvl[bsc_pkg::PIN_SPME];

	bsc_evt_flag u_pme_flag (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_set     (pme_fall),
		.i_clr     (i_pme_stat_clr),
		.o_flag    (pme_stat_q)
	);

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pme_oe_q <= 1'b0;
		end else if (pri_rise) begin
			if (pme_fall && i_pme_state_ok && i_pme_en) begin
				pme_oe_q <= 1'b1;
			end else if (!pme_stat_q || !i_pme_en) begin
				pme_oe_q <= 1'b0;
			end
		end
	end

	assign o_pme_stat = pme_stat_q;
	assign o_pme_o    = 1'b0;
	assign o_pme_oe   = pme_oe_q;

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	sequence s_pme_trig;
		pme_fall && i_pme_state_ok && i_pme_en;
	endsequence

	sequence s_pme_drop;
		pri_rise && !pme_fall && (!pme_stat_q || !i_pme_en);
	endsequence

	AST_PRI_LAUNCH: assert property (
		$changed(o_hs_event_oe) || $changed(o_pme_oe) |-> $past(pri_rise))
		else $error("primary output moved without primary edge");
	AST_SEC_LAUNCH: assert property (
		$changed(o_lstat_oe) || $changed(o_lstat_o) |-> $past(sec_rise))
		else $error("status pin moved without secondary edge");
	AST_STOPPED_HOLD: assert property (
		!pri_rise [*2] |=> $stable(o_pme_oe))
		else $error("power event moved with primary clock stopped");
	AST_SCLK_FOLLOW: assert property (
		pri_rise && !strap_off_q ##1 !i_sec_clk_dis |=> o_sec_clk_out)
		else $error("secondary clock missed primary high");
	AST_SCLK_DIS: assert property (
		i_sec_clk_dis || strap_off_q |=> !o_sec_clk_out)
		else $error("disabled secondary clock not low");
	AST_LED_STATE: assert property (
		!o_lstat_oe |-> o_led_state == o_ejector_open)
		else $error("led state not ejector state");
	AST_LED_DRIVE: assert property (
		sec_rise && i_lstat_drive |=> o_lstat_oe
		&& o_lstat_o == $past(i_led_on))
		else $error("led value not driven");
	AST_ENUM_SET: assert property (
		pri_rise && (ins_q || rem_q) && i_hs_evt_en |=> o_hs_event_oe)
		else $error("hot swap event not asserted");
	AST_ENUM_REL: assert property (
		pri_rise && !ins_q && !rem_q |=> !o_hs_event_oe)
		else $error("hot swap event not released");
	AST_ENUM_OFF: assert property (
		pri_rise && !i_hs_evt_en |=> !o_hs_event_oe)
		else $error("hot swap event asserted while disabled");
	AST_PME_SET: assert property (
		s_pme_trig |=> o_pme_oe && o_pme_stat)
		else $error("power event not asserted");
	AST_PME_REL: assert property (
		s_pme_drop |=> !o_pme_oe)
		else $error("power event not released");
	AST_PME_EDGE: assert property (
		pme_fall |=> o_pme_stat)
		else $error("falling edge not recorded");
	AST_PME_NEED: assert property (
		$rose(o_pme_oe) |-> $past(i_pme_en) && $past(i_pme_state_ok))
		else $error("power event asserted without conditions");
	AST_RST_CLEAR: assert property (@(posedge i_clk_sys)
		disable iff (1'b0) $rose(i_arst_n) |-> !o_pme_oe
		&& !o_hs_event_oe && !o_pme_stat && !o_ins_stat)
		else $error("reset left event state");
	AST_OD_LOW: assert property (
		!o_pme_o && !o_hs_event_o)
		else $error("open-drain output driven high");
endmodule // bsc_top

// [bsc_top_tb_top.sv]
// testbench for the clock and sideband event block
`timescale 1ns/1ns
module bsc_top_tb_top;
	logic i_clk_sys, i_arst_n, clk_run, ejector, pme_req;
	logic i_sec_clk_dis, i_lstat_drive, i_led_on, i_hs_evt_en;
	logic i_ins_clr, i_rem_clr, i_pme_en, i_pme_state_ok, i_pme_stat_clr;
	logic [bsc_pkg::ROM_BUS_W-1:0] i_rom_addr_data_bus;
	wire logic pri_clk, sec_clk, lstat_pin, sec_pme_n;
	logic o_sec_clk_out, o_sec_clk_strap_off, o_lstat_o, o_lstat_oe;
	logic o_ejector_open, o_led_state, o_ins_stat, o_rem_stat;
	logic o_hs_event_o, o_hs_event_oe, o_pme_stat, o_pme_o, o_pme_oe;
	logic sc_p, pc_p;
	int   n_errors, num_checks, sc_n, pc_n, ds, dp;

	bsc_top u_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
		.i_pri_clk(pri_clk), .i_sec_clk(sec_clk),
		.o_sec_clk_out(o_sec_clk_out), .i_sec_clk_dis(i_sec_clk_dis),
		.i_rom_addr_data_bus(i_rom_addr_data_bus),
		.o_sec_clk_strap_off(o_sec_clk_strap_off), .i_lstat_i(lstat_pin),
		.o_lstat_o(o_lstat_o), .o_lstat_oe(o_lstat_oe),
		.i_lstat_drive(i_lstat_drive), .i_led_on(i_led_on),
		.o_ejector_open(o_ejector_open), .o_led_state(o_led_state),
		.i_hs_evt_en(i_hs_evt_en), .i_ins_clr(i_ins_clr),
		.i_rem_clr(i_rem_clr), .o_ins_stat(o_ins_stat),
		.o_rem_stat(o_rem_stat), .o_hs_event_o(o_hs_event_o),
		.o_hs_event_oe(o_hs_event_oe), .i_sec_pme_n(sec_pme_n),
		.i_pme_en(i_pme_en), .i_pme_state_ok(i_pme_state_ok),
		.i_pme_stat_clr(i_pme_stat_clr), .o_pme_stat(o_pme_stat),
		.o_pme_o(o_pme_o), .o_pme_oe(o_pme_oe));

	bsc_host_model u_host (.i_clk_run(clk_run), .i_ejector(ejector),
		.i_pme_req(pme_req), .i_sec_clk_out(o_sec_clk_out),
		.i_lstat_o(o_lstat_o), .i_lstat_oe(o_lstat_oe),
		.o_pri_clk(pri_clk), .o_sec_clk(sec_clk),
		.o_lstat_pin(lstat_pin), .o_sec_pme_n(sec_pme_n));

	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	// rising edges of both clocks, counted in the system domain
	always @(posedge i_clk_sys) begin
		sc_p <= o_sec_clk_out;
		pc_p <= pri_clk;
		if (o_sec_clk_out === 1'b1 && sc_p === 1'b0) sc_n++;
		if (pri_clk === 1'b1 && pc_p === 1'b0) pc_n++;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	task automatic span(input int n);
		int s0;
		int p0;
		s0 = sc_n;
		p0 = pc_n;
		cyc(n);
		ds = sc_n - s0;
		dp = pc_n - p0;
	endtask

	task automatic pulse(input int k);
		@(posedge i_clk_sys);
		case (k)
			0: i_ins_clr <= 1'b1;
			1: i_rem_clr <= 1'b1;
			default: i_pme_stat_clr <= 1'b1;
		endcase
		@(posedge i_clk_sys);
		i_ins_clr <= 1'b0;
		i_rem_clr <= 1'b0;
		i_pme_stat_clr <= 1'b0;
	endtask

	task automatic pme_case(input logic en, input logic ok, input logic eo);
		@(posedge i_clk_sys);
		i_pme_en <= en;
		i_pme_state_ok <= ok;
		@(posedge i_clk_sys);
		pme_req <= 1'b1;
		cyc(30);
		check("pme_stat", o_pme_stat, 1'b1);
		check("pme_oe", o_pme_oe, eo);
		check("pme_o", o_pme_o, 1'b0);
		pulse(2);
		cyc(30);
		check("pme_stat_clr", o_pme_stat, 1'b0);
		check("pme_oe_rel", o_pme_oe, 1'b0);
		@(posedge i_clk_sys);
		pme_req <= 1'b0;
		cyc(30);
	endtask

	initial begin
		#200000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		i_arst_n = 1'b0; clk_run = 1'b1; ejector = 1'b0; pme_req = 1'b0;
		i_sec_clk_dis = 1'b0; i_lstat_drive = 1'b0; i_led_on = 1'b0;
		i_hs_evt_en = 1'b1; i_ins_clr = 1'b0; i_rem_clr = 1'b0;
		i_pme_en = 1'b0; i_pme_state_ok = 1'b0; i_pme_stat_clr = 1'b0;
		i_rom_addr_data_bus = 8'h20;
		cyc(12);
		check("strap_off_rst", o_sec_clk_strap_off, 1'b1);
		i_arst_n <= 1'b1;
		cyc(20);
		check("strap_off", o_sec_clk_strap_off, 1'b0);
		span(320);
		check("sec_rate", (ds - dp <= 1) && (dp - ds <= 1) && dp > 30, 1);
		@(posedge i_clk_sys);
		i_sec_clk_dis <= 1'b1;
		cyc(3);
		span(160);
		check("sec_dis_rises", ds, 0);
		check("sec_dis_lvl", o_sec_clk_out, 1'b0);
		i_sec_clk_dis <= 1'b0;
		clk_run <= 1'b0;
		cyc(20);
		span(160);
		check("sec_stopped", ds, 0);
		clk_run <= 1'b1;
		cyc(20);
		span(160);
		check("sec_restart", ds >= 18, 1);
		ejector <= 1'b1;
		cyc(60);
		check("ejector", o_ejector_open, 1'b1);
		check("led_in", o_led_state, 1'b1);
		check("rem_stat", o_rem_stat, 1'b1);
		check("hs_oe_rem", o_hs_event_oe, 1'b1);
		check("hs_o", o_hs_event_o, 1'b0);
		i_hs_evt_en <= 1'b0;
		cyc(30);
		check("hs_oe_off", o_hs_event_oe, 1'b0);
		check("rem_kept", o_rem_stat, 1'b1);
		i_hs_evt_en <= 1'b1;
		cyc(30);
		check("hs_oe_on", o_hs_event_oe, 1'b1);
		pulse(1);
		cyc(30);
		check("rem_clr", o_rem_stat, 1'b0);
		check("hs_oe_rel", o_hs_event_oe, 1'b0);
		ejector <= 1'b0;
		cyc(60);
		check("ins_stat", o_ins_stat, 1'b1);
		check("hs_oe_ins", o_hs_event_oe, 1'b1);
		pulse(0);
		cyc(30);
		check("ins_clr", o_ins_stat, 1'b0);
		check("hs_oe_rel2", o_hs_event_oe, 1'b0);
		i_lstat_drive <= 1'b1;
		i_led_on <= 1'b1;
		cyc(60);
		check("lstat_oe", o_lstat_oe, 1'b1);
		check("lstat_o", o_lstat_o, 1'b1);
		check("led_drv", o_led_state, 1'b1);
		i_led_on <= 1'b0;
		cyc(40);
		check("lstat_o0", o_lstat_o, 1'b0);
		check("led_drv0", o_led_state, 1'b0);
		i_lstat_drive <= 1'b0;
		cyc(40);
		check("lstat_oe0", o_lstat_oe, 1'b0);
		check("no_ins", o_ins_stat, 1'b0);
		pme_case(1'b0, 1'b1, 1'b0);
		pme_case(1'b1, 1'b0, 1'b0);
		pme_case(1'b1, 1'b1, 1'b1);
		pme_req <= 1'b1;
		cyc(30);
		check("pme_oe_on", o_pme_oe, 1'b1);
		i_pme_en <= 1'b0;
		cyc(30);
		check("pme_oe_en0", o_pme_oe, 1'b0);
		check("pme_stat_kept", o_pme_stat, 1'b1);
		i_pme_en <= 1'b1;
		pme_req <= 1'b0;
		cyc(30);
		pme_req <= 1'b1;
		cyc(30);
		check("pme_oe_again", o_pme_oe, 1'b1);
		i_arst_n <= 1'b0;
		i_rom_addr_data_bus <= 8'h00;
		pme_req <= 1'b0;
		cyc(2);
		check("rst_pme_stat", o_pme_stat, 1'b0);
		check("rst_pme_oe", o_pme_oe, 1'b0);
		check("rst_strap", o_sec_clk_strap_off, 1'b1);
		cyc(10);
		i_arst_n <= 1'b1;
		cyc(40);
		check("strap_low", o_sec_clk_strap_off, 1'b1);
		span(160);
		check("strap_rises", ds, 0);
		check("pme_oe_after", o_pme_oe, 1'b0);
		tally_and_finish();
	end
endmodule // bsc_top_tb_top
